/* File: hdl/ascs_host.sv */
// Host end: walks the startup sequence and programs the device
`default_nettype none
module ascs_host (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // Software register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Status
   output logic BUSY,
   // Programming link
   ascs_if.host lnk
);
   ascs_pkg::ascs_hstate_t st_reg, st_next;
   logic [7:0] ctrl_reg, mode_reg, cal_reg, devstat_reg;
   logic [7:0] cnt_reg;
   logic done_reg, wr_reg, clk_ok_reg, sync_reg;
   logic [7:0] addr_reg, wdata_reg;
   wire start = WR && ADDR == ascs_pkg::HR_CTRL && WDATA[ascs_pkg::CTRL_START];
   wire busy = st_reg != ascs_pkg::HS_IDLE && st_reg != ascs_pkg::HS_DONE;
   wire cnt_zero = cnt_reg == 8'h00;
   wire [7:0] rd_mux =
      ADDR == ascs_pkg::HR_CTRL ? ctrl_reg :
      ADDR == ascs_pkg::HR_MODE ? mode_reg :
      ADDR == ascs_pkg::HR_CAL ? cal_reg :
      ADDR == ascs_pkg::HR_STATUS ? {6'h00, done_reg, busy} :
      ADDR == ascs_pkg::HR_DEVSTAT ? devstat_reg : 8'h00;
   // Steps run strictly in order, one write per state except HS_IDLE, HS_SETTLE, HS_SYNC and HS_DONE, which write nothing; see [R04] see [R16]
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         ascs_pkg::HS_IDLE: if (start) st_next = ascs_pkg::HS_SETTLE;
         ascs_pkg::HS_SETTLE:
            if (cnt_zero) st_next = ascs_pkg::HS_LINK_OFF; // see [R05]
         ascs_pkg::HS_LINK_OFF: st_next = ascs_pkg::HS_CAL_OFF;
         ascs_pkg::HS_CAL_OFF: st_next = ascs_pkg::HS_MODE;
         ascs_pkg::HS_MODE: st_next = ascs_pkg::HS_SYNC_SEL;
         ascs_pkg::HS_SYNC_SEL: st_next = ascs_pkg::HS_CAL_CFG;
         ascs_pkg::HS_CAL_CFG: st_next = ascs_pkg::HS_CAL_ON;
         ascs_pkg::HS_CAL_ON: st_next = ascs_pkg::HS_OVR;
         ascs_pkg::HS_OVR: st_next = ascs_pkg::HS_LINK_ON;
         ascs_pkg::HS_LINK_ON: st_next = ctrl_reg[ascs_pkg::CTRL_SYNC]
            ? ascs_pkg::HS_SYNC : ascs_pkg::HS_TRIG0;
         ascs_pkg::HS_SYNC: if (cnt_zero) st_next = ascs_pkg::HS_TRIG0;
         ascs_pkg::HS_TRIG0: st_next = ctrl_reg[ascs_pkg::CTRL_TRIG]
            ? ascs_pkg::HS_TRIG1 : ascs_pkg::HS_DONE;
         ascs_pkg::HS_TRIG1: st_next = ascs_pkg::HS_DONE;
         ascs_pkg::HS_DONE: if (start) st_next = ascs_pkg::HS_SETTLE;
         default: st_next = ascs_pkg::HS_IDLE;
      endcase
   end
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_reg <= ascs_pkg::HS_IDLE;
         ctrl_reg <= 8'h00;
         mode_reg <= ascs_pkg::OUT_MODE_RST;
         cal_reg <= ascs_pkg::CAL_CFG_RST;
         RDATA <= 8'h00;
         BUSY <= 1'b0;
      end else begin
         st_reg <= st_next;
         if (WR && ADDR == ascs_pkg::HR_CTRL) ctrl_reg <= WDATA;
         if (WR && ADDR == ascs_pkg::HR_MODE) mode_reg <= WDATA;
         if (WR && ADDR == ascs_pkg::HR_CAL) cal_reg <= WDATA;
         RDATA <= RD ? rd_mux : 8'h00;
         BUSY <= st_next != ascs_pkg::HS_IDLE
            && st_next != ascs_pkg::HS_DONE;
      end
   end
   // Counters, done flag, device status snapshot
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_reg <= 8'h00;
         done_reg <= 1'b0;
         devstat_reg <= 8'h00;
      end else begin
         if (st_reg != st_next && st_next == ascs_pkg::HS_SETTLE)
            cnt_reg <= 8'(ascs_pkg::CLK_SETTLE_CYC - 1);
         else if (st_reg != st_next && st_next == ascs_pkg::HS_SYNC)
            cnt_reg <= 8'(ascs_pkg::SYNC_CYC - 1);
         else if (!cnt_zero)
            cnt_reg <= cnt_reg - 8'h01;
         // Set wins over a start in the same cycle
         if (st_next == ascs_pkg::HS_DONE && st_reg != ascs_pkg::HS_DONE)
            done_reg <= 1'b1;
         else if (start)
            done_reg <= 1'b0;
         devstat_reg <= lnk.rdata;
      end
   end
   // One write per step; the write lands in the cycle after the state
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_reg <= 1'b0;
         addr_reg <= ascs_pkg::DEV_STATUS;
         wdata_reg <= 8'h00;
         clk_ok_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         wr_reg <= 1'b1;
         addr_reg <= ascs_pkg::DEV_STATUS;
         wdata_reg <= 8'h00;
         clk_ok_reg <= st_reg != ascs_pkg::HS_IDLE; // see [R05]
         sync_reg <= st_reg == ascs_pkg::HS_SYNC; // see [R14]
         case (st_reg)
            ascs_pkg::HS_LINK_OFF: begin
               addr_reg <= ascs_pkg::DEV_LINK_EN; // see [R06]
            end
            ascs_pkg::HS_CAL_OFF: begin
               addr_reg <= ascs_pkg::DEV_CAL_EN; // see [R07]
            end
            ascs_pkg::HS_MODE: begin
               addr_reg <= ascs_pkg::DEV_OUT_MODE; // see [R08]
               wdata_reg <= mode_reg; // see [R01] see [R02] see [R03]
            end
            ascs_pkg::HS_SYNC_SEL: begin
               addr_reg <= ascs_pkg::DEV_SYNC_SEL; // see [R09]
               wdata_reg <= {7'h00, ctrl_reg[ascs_pkg::CTRL_SYNC_SEL]};
            end
            ascs_pkg::HS_CAL_CFG: begin
               addr_reg <= ascs_pkg::DEV_CAL_CFG; // see [R10]
               wdata_reg <= cal_reg;
            end
            ascs_pkg::HS_CAL_ON: begin
               addr_reg <= ascs_pkg::DEV_CAL_EN; // see [R11]
               wdata_reg <= 8'h01;
            end
            ascs_pkg::HS_OVR: begin
               addr_reg <= ascs_pkg::DEV_OVERRANGE_ENABLE; // see [R12]
               wdata_reg <= {7'h00, ctrl_reg[ascs_pkg::CTRL_OVR]};
            end
            ascs_pkg::HS_LINK_ON: begin
               addr_reg <= ascs_pkg::DEV_LINK_EN; // see [R13]
               wdata_reg <= 8'h01;
            end
            ascs_pkg::HS_TRIG0: begin
               addr_reg <= ascs_pkg::DEV_SOFT_TRIG; // see [R15]
            end
            ascs_pkg::HS_TRIG1: begin
               addr_reg <= ascs_pkg::DEV_SOFT_TRIG; // see [R15]
               wdata_reg <= 8'h01;
            end
            default: wr_reg <= 1'b0;
         endcase
      end
   end
   assign lnk.wr = wr_reg;
   assign lnk.addr = addr_reg;
   assign lnk.wdata = wdata_reg;
   assign lnk.clk_ok = clk_ok_reg;
   assign lnk.sync_se = sync_reg && !ctrl_reg[ascs_pkg::CTRL_SYNC_SEL];
   assign lnk.sync_ts = sync_reg && ctrl_reg[ascs_pkg::CTRL_SYNC_SEL];
endmodule
`default_nettype wire

/* File: hdl/ascs_pkg.sv */
// Package: register map, field layout and timing constants of the sequencer
`default_nettype none
package ascs_pkg;
   // Device register addresses over the serial programming link
   localparam logic [7:0] DEV_LINK_EN = 8'h00;
   localparam logic [7:0] DEV_CAL_EN = 8'h01;
   localparam logic [7:0] DEV_OUT_MODE = 8'h02;
   localparam logic [7:0] DEV_SYNC_SEL = 8'h03;
   localparam logic [7:0] DEV_CAL_CFG = 8'h04;
   localparam logic [7:0] DEV_OVERRANGE_ENABLE = 8'h05;
   localparam logic [7:0] DEV_SOFT_TRIG = 8'h06;
   localparam logic [7:0] DEV_STATUS = 8'h07;
   // Output mode fields
   localparam int MODE_DUAL_EDGE = 0;
   localparam int MODE_DEMUX = 1;
   localparam int MODE_ALIGN = 2;
   // Calibration config fields
   localparam int CAL_BACKGROUND = 0;
   localparam int CAL_OFFSET = 1;
   // Reset values
   localparam logic [7:0] OUT_MODE_RST = 8'h00;
   localparam logic [7:0] CAL_CFG_RST = 8'h00;
   // Sample rates in MSPS
   localparam int RATE_SINGLE_MSPS = 6400;
   localparam int RATE_DUAL_MSPS = 3200;
   // Host register offsets
   localparam logic [3:0] HR_CTRL = 4'h0;
   localparam logic [3:0] HR_MODE = 4'h1;
   localparam logic [3:0] HR_CAL = 4'h2;
   localparam logic [3:0] HR_STATUS = 4'h3;
   localparam logic [3:0] HR_DEVSTAT = 4'h4;
   // Host control bits
   localparam int CTRL_START = 0;
   localparam int CTRL_SYNC = 1;
   localparam int CTRL_TRIG = 2;
   localparam int CTRL_SYNC_SEL = 3;
   localparam int CTRL_OVR = 4;
   // Wait for the sampling clock to settle
   localparam int CLK_SETTLE_NS = 1000;
   localparam int CORE_CLK_NS = 100;
   localparam int CLK_SETTLE_CYC = (CLK_SETTLE_NS + CORE_CLK_NS - 1)
      / CORE_CLK_NS;
   // Length of the sync request pulse
   localparam int SYNC_CYC = 4;
   typedef enum {
      HS_IDLE, HS_SETTLE, HS_LINK_OFF, HS_CAL_OFF, HS_MODE, HS_SYNC_SEL,
      HS_CAL_CFG, HS_CAL_ON, HS_OVR, HS_LINK_ON, HS_SYNC, HS_TRIG0,
      HS_TRIG1, HS_DONE
   } ascs_hstate_t;
endpackage
`default_nettype wire

/* File: hdl/ascs_if.sv */
// Interface: serial programming link and sync inputs between host and device
`default_nettype none
interface ascs_if;
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic clk_ok;
   logic sync_se;
   logic sync_ts;
   modport host (output wr, output addr, output wdata, output clk_ok,
      output sync_se, output sync_ts, input rdata);
   modport dev (input wr, input addr, input wdata, input clk_ok,
      input sync_se, input sync_ts, output rdata);
endinterface
`default_nettype wire

/* File: hdl/ascs_dev.sv */
// Device end: configuration registers and the link, calibration machines
// Behaviour
// [R01] Dual-edge bit selects single 6.4 or dual 3.2
// [R02] Demux spreads to four buses; align clear staggers
// [R03] Mode changes only by register writes
// [R04] Host keeps the prescribed step order
// [R05] Host applies stable clock before programming
// [R06] Link enable zero halts link machine
// [R07] Calibration enable zero halts calibration machine
// [R08] Host writes output mode while link halted
// [R09] Sync select picks single-ended or timestamp input
// [R10] Calibration config: background and offset, while halted
// [R11] Calibration enable one restarts calibration machine
// [R12] Host sets overrange before link enable
// [R13] Link enable one starts output interface
// [R14] Selected sync makes device send strobe
// [R15] Trigger rising edge starts a calibration
// [R16] Host finishes each write before next step
`default_nettype none
module ascs_dev (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // Programming link
   ascs_if.dev lnk,
   // Device state seen by the user side
   output logic LINK_RUN,
   output logic CAL_RUN,
   output logic CAL_BUSY,
   output logic STROBE,
   output logic SINGLE_CH,
   output logic [12:0] RATE_MSPS,
   output logic [2:0] BUS_COUNT_M1,
   output logic BUS_ALIGNED,
   output logic OVR_ON,
   output logic CAL_BG,
   output logic CAL_OFS
);
   logic link_en_reg, cal_en_reg, sync_sel_reg, ovr_reg, trig_reg;
   logic [7:0] mode_reg, cal_cfg_reg;
   logic cal_busy_reg;
   logic [3:0] cal_cnt_reg;
   logic strobe_reg;
   logic [7:0] rdata_reg;
   wire wr_link = lnk.wr && lnk.addr == ascs_pkg::DEV_LINK_EN;
   wire wr_cal = lnk.wr && lnk.addr == ascs_pkg::DEV_CAL_EN;
   // Output mode and calibration config are taken only while their machine is halted; sync select and overrange at any time
   wire wr_mode = lnk.wr && lnk.addr == ascs_pkg::DEV_OUT_MODE
      && !link_en_reg; // see [R06]
   wire wr_ccfg = lnk.wr && lnk.addr == ascs_pkg::DEV_CAL_CFG
      && !cal_en_reg; // see [R07] see [R10]
   wire wr_ssel = lnk.wr && lnk.addr == ascs_pkg::DEV_SYNC_SEL;
   wire wr_ovr = lnk.wr && lnk.addr == ascs_pkg::DEV_OVERRANGE_ENABLE;
   wire wr_trig = lnk.wr && lnk.addr == ascs_pkg::DEV_SOFT_TRIG;
   wire trig_rise = wr_trig && lnk.wdata[0] && !trig_reg; // see [R15]
   wire sync_in = sync_sel_reg ? lnk.sync_ts : lnk.sync_se; // see [R09]
   wire single = mode_reg[ascs_pkg::MODE_DUAL_EDGE];
   wire [7:0] status = {3'h0, strobe_reg, ovr_reg, cal_busy_reg,
      cal_en_reg, link_en_reg};
   wire [7:0] rd_mux =
      lnk.addr == ascs_pkg::DEV_OUT_MODE ? mode_reg :
      lnk.addr == ascs_pkg::DEV_CAL_CFG ? cal_cfg_reg :
      lnk.addr == ascs_pkg::DEV_STATUS ? status : 8'h00;
   assign lnk.rdata = rdata_reg;
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         link_en_reg <= 1'b0;
         cal_en_reg <= 1'b0;
         sync_sel_reg <= 1'b0;
         ovr_reg <= 1'b0;
         trig_reg <= 1'b0;
         mode_reg <= ascs_pkg::OUT_MODE_RST;
         cal_cfg_reg <= ascs_pkg::CAL_CFG_RST;
         rdata_reg <= 8'h00;
      end else begin
         if (wr_link) link_en_reg <= lnk.wdata[0]; // see [R06] see [R13]
         if (wr_cal) cal_en_reg <= lnk.wdata[0]; // see [R07] see [R11]
         if (wr_mode) mode_reg <= lnk.wdata; // see [R03]
         if (wr_ccfg) cal_cfg_reg <= lnk.wdata;
         if (wr_ssel) sync_sel_reg <= lnk.wdata[0];
         if (wr_ovr) ovr_reg <= lnk.wdata[0];
         if (wr_trig) trig_reg <= lnk.wdata[0];
         rdata_reg <= rd_mux;
      end
   end
   // Calibration run: a fixed busy window; halting calibration aborts it
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cal_busy_reg <= 1'b0;
         cal_cnt_reg <= 4'h0;
      end else if (!cal_en_reg) begin
         cal_busy_reg <= 1'b0; // see [R07]
         cal_cnt_reg <= 4'h0;
      end else if (trig_rise) begin
         cal_busy_reg <= 1'b1; // see [R15]
         cal_cnt_reg <= 4'hf;
      end else if (cal_cnt_reg != 4'h0) begin
         cal_cnt_reg <= cal_cnt_reg - 4'h1;
         cal_busy_reg <= cal_cnt_reg != 4'h1;
      end
   end
   // Strobe only when the link runs; see [R14]
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) strobe_reg <= 1'b0;
      else strobe_reg <= link_en_reg && sync_in;
   end
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         LINK_RUN <= 1'b0;
         CAL_RUN <= 1'b0;
         CAL_BUSY <= 1'b0;
         STROBE <= 1'b0;
         SINGLE_CH <= 1'b0;
         RATE_MSPS <= 13'h0000;
         BUS_COUNT_M1 <= 3'h0;
         BUS_ALIGNED <= 1'b0;
         OVR_ON <= 1'b0;
         CAL_BG <= 1'b0;
         CAL_OFS <= 1'b0;
      end else begin
         LINK_RUN <= link_en_reg; // see [R13]
         CAL_RUN <= cal_en_reg; // see [R11]
         CAL_BUSY <= cal_busy_reg;
         STROBE <= strobe_reg;
         SINGLE_CH <= single; // see [R01]
         RATE_MSPS <= single ? 13'(ascs_pkg::RATE_SINGLE_MSPS)
            : 13'(ascs_pkg::RATE_DUAL_MSPS);
         BUS_COUNT_M1 <= mode_reg[ascs_pkg::MODE_DEMUX] ? 3'h3
            : 3'h1; // see [R02]
         BUS_ALIGNED <= mode_reg[ascs_pkg::MODE_ALIGN]; // see [R02]
         OVR_ON <= ovr_reg;
         CAL_BG <= cal_cfg_reg[ascs_pkg::CAL_BACKGROUND];
         CAL_OFS <= cal_cfg_reg[ascs_pkg::CAL_OFFSET];
      end
   end
endmodule
`default_nettype wire

/* File: verif/ascs_props.sv */
// Checker: step order and pulse shape on the programming link
`default_nettype none
module ascs_props (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // Programming link
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic clk_ok,
   input wire logic sync_se,
   input wire logic sync_ts
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   wire sync_any = sync_se || sync_ts;
   wire trig_lo = wr && addr == ascs_pkg::DEV_SOFT_TRIG && !wdata[0];
   logic trig_lo_reg;
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         trig_lo_reg <= 1'b0;
      end else begin
         trig_lo_reg <= trig_lo;
      end
   end
   // A plain function, so steps may be combined with data tests
   function automatic logic step(input logic [7:0] a);
      return wr && addr == a;
   endfunction
   sequence cal_restart;
      step(ascs_pkg::DEV_CAL_EN) && wdata[0] ##1 step(ascs_pkg::DEV_OVERRANGE_ENABLE)
         ##1 step(ascs_pkg::DEV_LINK_EN) && wdata[0];
   endsequence
   clk_first_a: assert property (wr |-> clk_ok)
      else $error("link write before clock stable");
   settle_gap_a: assert property ($rose(clk_ok) |-> !wr [*8])
      else $error("link write inside settle time");
   link_halt_a: assert property (
      step(ascs_pkg::DEV_LINK_EN) && !wdata[0]
      |=> step(ascs_pkg::DEV_CAL_EN) && !wdata[0])
      else $error("calibration halt does not follow link halt");
   cal_halt_a: assert property (
      step(ascs_pkg::DEV_CAL_EN) && !wdata[0]
      |=> step(ascs_pkg::DEV_OUT_MODE)) else $error("mode write missing");
   mode_next_a: assert property (step(ascs_pkg::DEV_OUT_MODE)
      |=> step(ascs_pkg::DEV_SYNC_SEL)) else $error("sync select missing");
   sel_next_a: assert property (step(ascs_pkg::DEV_SYNC_SEL)
      |=> step(ascs_pkg::DEV_CAL_CFG)) else $error("cal config missing");
   cal_restart_a: assert property (
      step(ascs_pkg::DEV_CAL_CFG)
      |=> cal_restart) else $error("restart order broken");
   link_start_a: assert property (
      step(ascs_pkg::DEV_LINK_EN) && wdata[0]
      |-> ##[1:6] trig_lo) else $error("trigger clear missing");
   sync_len_a: assert property ($rose(sync_any)
      |-> sync_any [*4] ##1 !sync_any) else $error("sync pulse length");
   sync_one_a: assert property (!(sync_se && sync_ts))
      else $error("both sync inputs driven");
   sync_quiet_a: assert property (sync_any |-> !wr)
      else $error("link write during sync");
   trig_edge_a: assert property (
      step(ascs_pkg::DEV_SOFT_TRIG) && wdata[0]
      |-> trig_lo_reg) else $error("trigger set without prior clear");
endmodule
`default_nettype wire

/* File: verif/ascs_bench.sv */
// Bench: host and device ends joined, driven through the software port
`default_nettype none
module ascs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic busy, link_run, cal_run, cal_busy, strobe, single_ch;
   logic bus_aligned, ovr_on, cal_bg, cal_ofs;
   logic [12:0] rate_msps;
   logic [2:0] bus_count_m1;
   logic [31:0] rnd = 32'h37053fae;
   int bad_count = 0;
   int comparisons = 0;
   int se_n = 0;
   int ts_n = 0;
   int st_n = 0;
   ascs_if ascs_if_i ();
   ascs_host ascs_host_i (.CORE_CLK(core_clk), .RESETN(resetn), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BUSY(busy),
      .lnk(ascs_if_i));
   ascs_dev ascs_dev_i (.CORE_CLK(core_clk), .RESETN(resetn),
      .lnk(ascs_if_i), .LINK_RUN(link_run), .CAL_RUN(cal_run),
      .CAL_BUSY(cal_busy), .STROBE(strobe), .SINGLE_CH(single_ch),
      .RATE_MSPS(rate_msps), .BUS_COUNT_M1(bus_count_m1),
      .BUS_ALIGNED(bus_aligned), .OVR_ON(ovr_on), .CAL_BG(cal_bg),
      .CAL_OFS(cal_ofs));
   ascs_props ascs_props_i (.CORE_CLK(core_clk), .RESETN(resetn),
      .wr(ascs_if_i.wr), .addr(ascs_if_i.addr), .wdata(ascs_if_i.wdata),
      .rdata(ascs_if_i.rdata), .clk_ok(ascs_if_i.clk_ok),
      .sync_se(ascs_if_i.sync_se), .sync_ts(ascs_if_i.sync_ts));
   always #50 core_clk = ~core_clk;
   // Pulse widths counted per run, cleared between runs
   always @(posedge core_clk) begin
      se_n += int'(ascs_if_i.sync_se === 1'b1);
      ts_n += int'(ascs_if_i.sync_ts === 1'b1);
      st_n += int'(strobe === 1'b1);
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] exp_rate(input logic [7:0] m);
      return m[0] ? 16'(ascs_pkg::RATE_SINGLE_MSPS)
         : 16'(ascs_pkg::RATE_DUAL_MSPS);
   endfunction
   function automatic logic [7:0] exp_stat(input logic [4:0] k);
      return {4'h0, k[4], k[2], 2'b11};
   endfunction
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      @(negedge core_clk);
      d = rdata;
   endtask
   // One full startup walk; k holds the control bits beside start
   task automatic run(input logic [7:0] m, input logic [7:0] c,
      input logic [4:0] k);
      logic [7:0] d;
      int n;
      n = 0;
      put(ascs_pkg::HR_MODE, m);
      put(ascs_pkg::HR_CAL, c);
      @(negedge core_clk);
      se_n = 0;
      ts_n = 0;
      st_n = 0;
      put(ascs_pkg::HR_CTRL, {3'b000, k[4:1], 1'b1});
      @(negedge core_clk);
      chk("busy start", 1, 16'(busy));
      while (busy !== 1'b0 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      chk("busy end", 0, 16'(busy));
      repeat (4) @(negedge core_clk);
      chk("single", 16'(m[0]), 16'(single_ch));
      chk("rate", exp_rate(m), 16'(rate_msps));
      chk("buses", m[1] ? 16'h3 : 16'h1, 16'(bus_count_m1));
      chk("aligned", 16'(m[2]), 16'(bus_aligned));
      chk("cal bg", 16'(c[0]), 16'(cal_bg));
      chk("cal ofs", 16'(c[1]), 16'(cal_ofs));
      chk("cal run", 1, 16'(cal_run));
      chk("link run", 1, 16'(link_run));
      chk("overrange", 16'(k[4]), 16'(ovr_on));
      chk("cal busy", 16'(k[2]), 16'(cal_busy));
      chk("sync se", (k[1] && !k[3]) ? 4 : 0, 16'(se_n));
      chk("sync ts", (k[1] && k[3]) ? 4 : 0, 16'(ts_n));
      chk("strobe", k[1] ? 4 : 0, 16'(st_n));
      get(ascs_pkg::HR_DEVSTAT, d);
      chk("dev status", 16'(exp_stat(k)), 16'(d));
      get(ascs_pkg::HR_STATUS, d);
      chk("host status", 16'h2, 16'(d));
      get(ascs_pkg::HR_MODE, d);
      chk("mode readback", 16'(m), 16'(d));
      get(ascs_pkg::HR_CAL, d);
      chk("cal readback", 16'(c), 16'(d));
      repeat (12) @(negedge core_clk);
      chk("cal busy end", 0, 16'(cal_busy));
   endtask
   initial begin
      #(20000 * 100);
      bad_count++;
      print_verdict();
   end
   initial begin
      logic [7:0] d;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(negedge core_clk);
      chk("link reset", 0, 16'(link_run));
      get(4'hf, d);
      chk("unmapped", 0, 16'(d));
      run(8'h00, 8'h00, 5'h00);
      run(8'h07, 8'h03, 5'h1e);
      run(8'h01, 8'h01, 5'h02);
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         run(rnd[7:0] & 8'h07, rnd[15:8] & 8'h03, rnd[20:16]);
      end
      // Reset in mid-sequence must drop every run flag at once
      put(ascs_pkg::HR_CTRL, 8'h01);
      repeat (15) @(posedge core_clk);
      resetn <= 1'b0;
      @(negedge core_clk);
      chk("link mid reset", 0, 16'(link_run));
      chk("cal mid reset", 0, 16'(cal_run));
      chk("busy mid reset", 0, 16'(busy));
      @(posedge core_clk);
      resetn <= 1'b1;
      run(8'h06, 8'h02, 5'h16);
      print_verdict();
   end
endmodule
`default_nettype wire
